//--- hdl/jcpp_pkg.sv
package jcpp_pkg;
	localparam int IR_W      = 8;
	localparam int ADDR_W    = 10;
	localparam int COL_W     = 90;
	localparam int ID_W      = 32;
	localparam int SIG_W     = 32;
	localparam int BSR_W     = 16;
	localparam int COL_DEPTH = 1024;

	// identity value is arbitrary, not any maker's code
	localparam logic [31:0] ID_VALUE = 32'h0a5c_3001;

	localparam logic [7:0] OP_EXTEST     = 8'h00;
	localparam logic [7:0] OP_ADDR_SHIFT = 8'h01;
	localparam logic [7:0] OP_DATA_SHIFT = 8'h02;
	localparam logic [7:0] OP_BULK_ERASE = 8'h03;
	localparam logic [7:0] OP_PROGRAM    = 8'h07;
	localparam logic [7:0] OP_FUSE_PROG  = 8'h09;
	localparam logic [7:0] OP_VERIFY     = 8'h0a;
	localparam logic [7:0] OP_DISCHARGE  = 8'h14;
	localparam logic [7:0] OP_PROG_EN    = 8'h15;
	localparam logic [7:0] OP_IDCODE     = 8'h16;
	localparam logic [7:0] OP_USERCODE   = 8'h17;
	localparam logic [7:0] OP_STORE_SIG  = 8'h1a;
	localparam logic [7:0] OP_PROG_DIS   = 8'h1e;
	localparam logic [7:0] OP_HIGHZ      = 8'h18;
	localparam logic [7:0] OP_SAMPLE     = 8'h1c;
	localparam logic [7:0] OP_CLAMP      = 8'h20;
	localparam logic [7:0] OP_INTEST     = 8'h2c;
	localparam logic [7:0] OP_ERASE_DONE = 8'h24;
	localparam logic [7:0] OP_WR_STEP    = 8'h27;
	localparam logic [7:0] OP_RD_STEP    = 8'h2a;
	localparam logic [7:0] OP_PROG_DONE  = 8'h2f;
	localparam logic [7:0] OP_NULL       = 8'h30;

	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_CTRL   = 12'h004;
	localparam logic [11:0] REG_ADDR   = 12'h008;

	localparam int ST_PROG  = 0;
	localparam int ST_FUSE  = 1;
	localparam int ST_DONE  = 2;
	localparam int ST_BUSY  = 3;
	localparam int ST_VPP   = 4;
	localparam int ST_IR_LO = 8;
	localparam int CTRL_EN  = 0;

	localparam logic CTRL_RESET = 1'b1;
	localparam logic DONE_RESET = 1'b0;

	typedef enum logic [3:0] {
		TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3, TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5,
		TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7, TAP_UP_DR  = 4'h8,
		TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR  = 4'hb,
		TAP_EX1_IR = 4'hc, TAP_PA_IR  = 4'hd, TAP_EX2_IR = 4'he,
		TAP_UP_IR  = 4'hf
	} jcpp_tap_t;

	typedef enum logic [2:0] {
		SEL_BYPASS = 3'h0, SEL_BSR = 3'h1, SEL_ID = 3'h2,
		SEL_SIG = 3'h3, SEL_ADDR = 3'h4, SEL_COL = 3'h5
	} jcpp_sel_t;

	typedef enum logic [1:0] {
		SQ_IDLE = 2'h0, SQ_ERASE = 2'h1, SQ_READ = 2'h2
	} jcpp_seq_t;
endpackage

//--- hdl/jcpp_col_mem.sv
`timescale 1ns/1ps
module jcpp_col_mem (
	input  wire logic                          pclk,
	input  wire logic                          we,
	input  wire logic                          re,
	input  wire logic [jcpp_pkg::ADDR_W-1:0]   addr,
	input  wire logic [jcpp_pkg::COL_W-1:0]    wdata,
	output logic      [jcpp_pkg::COL_W-1:0]    rdata
);
	logic [jcpp_pkg::COL_W-1:0] mem [jcpp_pkg::COL_DEPTH];

	// no reset on the array: contents are erased by the erase sequencer
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata <= mem[addr];
		end
	end
endmodule

//--- hdl/jcpp_port.sv
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
// Behaviour
// - instruction register is eight bits
// - extest drives pins, selects boundary register
// - msb set acts as bypass
// - sample captures pins into boundary register
// - idcode selects 32-bit identification register
// - id register selected after test-logic reset
// - address shift selects 10-bit address register
// - column data register, taken as 90 bits
// - program mode entered and left by codes
// - seven operations need program mode active
// - bulk erase clears array, signature, fuse
// - program writes column to addressed location
// - program then increment address
// - verify loads column, optional address increment
// - fuse locks readout, only erase or presetn clears
// - discharge drops programming supply flag
// - usercode copies stored signature, selects it
// - store signature only in program mode
// - highz floats all device outputs
// - clamp and null drive pins from boundary
// - intest selects internal functional test mode
// - done bit cleared and set by codes
// - capture-ir loads identification code
// - array operations start entering run-test/idle
module jcpp_port (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        tck,
	input  wire logic                        tms,
	input  wire logic                        tdi,
	output logic                             tdo_o,
	output logic                             tdo_oe_n,
	input  wire logic [jcpp_pkg::BSR_W-1:0]  pin_state,
	output logic      [jcpp_pkg::BSR_W-1:0]  bs_drive_value,
	output logic                             bs_drive_en,
	output logic                             outputs_highz,
	output logic                             extest_mode,
	output logic                             intest_mode,
	output logic                             normal_enable
);
	localparam int COLW = jcpp_pkg::COL_W;
	localparam int AW = jcpp_pkg::ADDR_W;

	logic [2:0] tck_sync, tms_sync, tdi_sync;
	logic [jcpp_pkg::BSR_W-1:0] pin_s1, pin_s2;
	logic tck_rise, tck_fall;
	jcpp_pkg::jcpp_tap_t tap_reg, tap_next;
	jcpp_pkg::jcpp_sel_t sel;
	jcpp_pkg::jcpp_seq_t seq_reg;
	logic [7:0] ir_shift_reg, ir_reg;
	logic bypass_reg;
	logic [jcpp_pkg::BSR_W-1:0] bsr_reg, bsr_upd_reg;
	logic [jcpp_pkg::ID_W-1:0] id_reg;
	logic [jcpp_pkg::SIG_W-1:0] user_signature, nv_sig_reg;
	logic [AW-1:0] addr_reg, erase_addr;
	logic [COLW-1:0] col_reg, mem_rdata;
	logic prog_mode_reg, readout_lock_fuse, done_reg, vpp_reg;
	logic ctrl_en_reg, step_after_read;
	logic op_start, pm_ok, mem_we, mem_re;
	logic [AW-1:0] mem_addr;
	logic [31:0] status;
	logic tdo_next;

	// first stage of each synchroniser feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_sync <= 3'h0;
			tms_sync <= 3'h7;
			tdi_sync <= 3'h0;
		end else begin
			tck_sync <= {tck_sync[1:0], tck};
			tms_sync <= {tms_sync[1:0], tms};
			tdi_sync <= {tdi_sync[1:0], tdi};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= pin_state;
			pin_s2 <= pin_s1;
		end
	end

	assign tck_rise = tck_sync[1] & ~tck_sync[2];
	assign tck_fall = ~tck_sync[1] & tck_sync[2];

	always_comb begin
		case (tap_reg)
		jcpp_pkg::TAP_RESET:  tap_next = tms_sync[1] ? jcpp_pkg::TAP_RESET
			: jcpp_pkg::TAP_IDLE;
		jcpp_pkg::TAP_IDLE:   tap_next = tms_sync[1] ? jcpp_pkg::TAP_SEL_DR
			: jcpp_pkg::TAP_IDLE;
		jcpp_pkg::TAP_SEL_DR: tap_next = tms_sync[1] ? jcpp_pkg::TAP_SEL_IR
			: jcpp_pkg::TAP_CAP_DR;
		jcpp_pkg::TAP_CAP_DR, jcpp_pkg::TAP_SH_DR: tap_next = tms_sync[1]
			? jcpp_pkg::TAP_EX1_DR : jcpp_pkg::TAP_SH_DR;
		jcpp_pkg::TAP_EX1_DR: tap_next = tms_sync[1] ? jcpp_pkg::TAP_UP_DR
			: jcpp_pkg::TAP_PA_DR;
		jcpp_pkg::TAP_PA_DR:  tap_next = tms_sync[1] ? jcpp_pkg::TAP_EX2_DR
			: jcpp_pkg::TAP_PA_DR;
		jcpp_pkg::TAP_EX2_DR: tap_next = tms_sync[1] ? jcpp_pkg::TAP_UP_DR
			: jcpp_pkg::TAP_SH_DR;
		jcpp_pkg::TAP_UP_DR, jcpp_pkg::TAP_UP_IR: tap_next = tms_sync[1]
			? jcpp_pkg::TAP_SEL_DR : jcpp_pkg::TAP_IDLE;
		jcpp_pkg::TAP_SEL_IR: tap_next = tms_sync[1] ? jcpp_pkg::TAP_RESET
			: jcpp_pkg::TAP_CAP_IR;
		jcpp_pkg::TAP_CAP_IR, jcpp_pkg::TAP_SH_IR: tap_next = tms_sync[1]
			? jcpp_pkg::TAP_EX1_IR : jcpp_pkg::TAP_SH_IR;
		jcpp_pkg::TAP_EX1_IR: tap_next = tms_sync[1] ? jcpp_pkg::TAP_UP_IR
			: jcpp_pkg::TAP_PA_IR;
		jcpp_pkg::TAP_PA_IR:  tap_next = tms_sync[1] ? jcpp_pkg::TAP_EX2_IR
			: jcpp_pkg::TAP_PA_IR;
		jcpp_pkg::TAP_EX2_IR: tap_next = tms_sync[1] ? jcpp_pkg::TAP_UP_IR
			: jcpp_pkg::TAP_SH_IR;
		default:              tap_next = jcpp_pkg::TAP_RESET;
		endcase
	end

	// a cleared port enable holds the controller in test-logic reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_reg <= jcpp_pkg::TAP_RESET;
		end else if (!ctrl_en_reg) begin
			tap_reg <= jcpp_pkg::TAP_RESET;
		end else if (tck_rise) begin
			tap_reg <= tap_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir_shift_reg <= jcpp_pkg::OP_IDCODE;
			ir_reg <= jcpp_pkg::OP_IDCODE;
		end else if (tap_reg == jcpp_pkg::TAP_RESET) begin
			ir_reg <= jcpp_pkg::OP_IDCODE;
		end else if (tck_rise) begin
			case (tap_reg)
			jcpp_pkg::TAP_CAP_IR: ir_shift_reg <= jcpp_pkg::OP_IDCODE;
			jcpp_pkg::TAP_SH_IR:
				ir_shift_reg <= {tdi_sync[1], ir_shift_reg[7:1]};
			jcpp_pkg::TAP_UP_IR: ir_reg <= ir_shift_reg;
			default: ;
			endcase
		end
	end

	always_comb begin
		case (ir_reg)
		jcpp_pkg::OP_EXTEST, jcpp_pkg::OP_SAMPLE, jcpp_pkg::OP_CLAMP,
		jcpp_pkg::OP_NULL, jcpp_pkg::OP_INTEST:
			sel = jcpp_pkg::SEL_BSR;
		jcpp_pkg::OP_IDCODE:     sel = jcpp_pkg::SEL_ID;
		jcpp_pkg::OP_USERCODE, jcpp_pkg::OP_STORE_SIG:
			sel = jcpp_pkg::SEL_SIG;
		jcpp_pkg::OP_ADDR_SHIFT: sel = jcpp_pkg::SEL_ADDR;
		jcpp_pkg::OP_DATA_SHIFT, jcpp_pkg::OP_PROGRAM, jcpp_pkg::OP_WR_STEP,
		jcpp_pkg::OP_VERIFY, jcpp_pkg::OP_RD_STEP:
			sel = jcpp_pkg::SEL_COL;
		default:                 sel = jcpp_pkg::SEL_BYPASS;
		endcase
	end

	wire dr_cap = tck_rise && tap_reg == jcpp_pkg::TAP_CAP_DR;
	wire dr_sh  = tck_rise && tap_reg == jcpp_pkg::TAP_SH_DR;
	wire dr_up  = tck_rise && tap_reg == jcpp_pkg::TAP_UP_DR;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bypass_reg <= 1'b0;
			id_reg <= '0;
		end else if (dr_cap) begin
			bypass_reg <= 1'b0;
			id_reg <= jcpp_pkg::ID_VALUE;
		end else if (dr_sh) begin
			bypass_reg <= tdi_sync[1];
			if (sel == jcpp_pkg::SEL_ID) begin
				id_reg <= {tdi_sync[1], id_reg[jcpp_pkg::ID_W-1:1]};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bsr_reg <= '0;
			bsr_upd_reg <= '0;
		end else if (sel == jcpp_pkg::SEL_BSR) begin
			if (dr_cap) begin
				bsr_reg <= pin_s2;
			end else if (dr_sh) begin
				bsr_reg <= {tdi_sync[1], bsr_reg[jcpp_pkg::BSR_W-1:1]};
			end else if (dr_up) begin
				bsr_upd_reg <= bsr_reg;
			end
		end
	end

	assign pm_ok = prog_mode_reg;
	assign op_start = tck_rise && tap_next == jcpp_pkg::TAP_IDLE
		&& tap_reg == jcpp_pkg::TAP_UP_IR;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_mode_reg <= 1'b0;
		end else if (tck_rise && tap_reg == jcpp_pkg::TAP_UP_IR) begin
			if (ir_shift_reg == jcpp_pkg::OP_PROG_EN) begin
				prog_mode_reg <= 1'b1;
			end else if (ir_shift_reg == jcpp_pkg::OP_PROG_DIS) begin
				prog_mode_reg <= 1'b0;
			end
		end
	end

	// bulk erase and array reads run from the sequencer; the tap keeps moving
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_reg <= jcpp_pkg::SQ_IDLE;
			erase_addr <= '0;
		end else begin
			case (seq_reg)
			jcpp_pkg::SQ_IDLE: begin
				erase_addr <= '0;
				if (op_start && pm_ok) begin
					case (ir_shift_reg)
					jcpp_pkg::OP_BULK_ERASE: seq_reg <= jcpp_pkg::SQ_ERASE;
					jcpp_pkg::OP_VERIFY, jcpp_pkg::OP_RD_STEP:
						seq_reg <= jcpp_pkg::SQ_READ;
					default: ;
					endcase
				end
			end
			jcpp_pkg::SQ_ERASE: begin
				erase_addr <= erase_addr + 1'b1;
				if (&erase_addr) begin
					seq_reg <= jcpp_pkg::SQ_IDLE;
				end
			end
			jcpp_pkg::SQ_READ: seq_reg <= jcpp_pkg::SQ_IDLE;
			default: seq_reg <= jcpp_pkg::SQ_IDLE;
			endcase
		end
	end

	wire do_write = op_start && pm_ok && seq_reg == jcpp_pkg::SQ_IDLE
		&& (ir_shift_reg == jcpp_pkg::OP_PROGRAM
		|| ir_shift_reg == jcpp_pkg::OP_WR_STEP);
	wire do_read = op_start && pm_ok && seq_reg == jcpp_pkg::SQ_IDLE
		&& (ir_shift_reg == jcpp_pkg::OP_VERIFY
		|| ir_shift_reg == jcpp_pkg::OP_RD_STEP);
	wire erasing = seq_reg == jcpp_pkg::SQ_ERASE;

	assign mem_we = do_write || erasing;
	assign mem_re = do_read;
	assign mem_addr = erasing ? erase_addr : addr_reg;

	jcpp_col_mem u_mem (
		.pclk  (pclk),
		.we    (mem_we),
		.re    (mem_re),
		.addr  (mem_addr),
		.wdata (erasing ? {COLW{1'b0}} : col_reg),
		.rdata (mem_rdata)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_after_read <= 1'b0;
		end else if (do_read) begin
			step_after_read <= ir_shift_reg == jcpp_pkg::OP_RD_STEP;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg <= '0;
		end else if (do_write && ir_shift_reg == jcpp_pkg::OP_WR_STEP) begin
			addr_reg <= addr_reg + 1'b1;
		end else if (seq_reg == jcpp_pkg::SQ_READ && step_after_read) begin
			addr_reg <= addr_reg + 1'b1;
		end else if (dr_sh && sel == jcpp_pkg::SEL_ADDR) begin
			addr_reg <= {tdi_sync[1], addr_reg[AW-1:1]};
		end
	end

	// a locked part reads back zeros instead of the array
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col_reg <= '0;
		end else if (seq_reg == jcpp_pkg::SQ_READ) begin
			col_reg <= readout_lock_fuse ? '0 : mem_rdata;
		end else if (dr_sh && sel == jcpp_pkg::SEL_COL) begin
			col_reg <= {tdi_sync[1], col_reg[COLW-1:1]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_signature <= '0;
		end else if (dr_cap && ir_reg == jcpp_pkg::OP_USERCODE) begin
			user_signature <= nv_sig_reg;
		end else if (dr_sh && sel == jcpp_pkg::SEL_SIG) begin
			user_signature <= {tdi_sync[1],
				user_signature[jcpp_pkg::SIG_W-1:1]};
		end
	end

	// non-volatile cells modelled as flops cleared by presetn and by bulk erase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nv_sig_reg <= '0;
			readout_lock_fuse <= 1'b0;
			vpp_reg <= 1'b0;
		end else if (op_start) begin
			case (ir_shift_reg)
			jcpp_pkg::OP_BULK_ERASE: if (pm_ok) begin
				nv_sig_reg <= '0;
				readout_lock_fuse <= 1'b0;
				vpp_reg <= 1'b1;
			end
			jcpp_pkg::OP_STORE_SIG: if (pm_ok) begin
				nv_sig_reg <= user_signature;
				vpp_reg <= 1'b1;
			end
			jcpp_pkg::OP_FUSE_PROG: if (pm_ok) begin
				readout_lock_fuse <= 1'b1;
				vpp_reg <= 1'b1;
			end
			jcpp_pkg::OP_PROGRAM, jcpp_pkg::OP_WR_STEP:
				if (pm_ok) vpp_reg <= 1'b1;
			jcpp_pkg::OP_DISCHARGE: vpp_reg <= 1'b0;
			default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= jcpp_pkg::DONE_RESET;
		end else if (op_start && ir_shift_reg == jcpp_pkg::OP_ERASE_DONE) begin
			done_reg <= 1'b0;
		end else if (op_start && ir_shift_reg == jcpp_pkg::OP_PROG_DONE) begin
			done_reg <= 1'b1;
		end
	end

	always_comb begin
		case (tap_reg)
		jcpp_pkg::TAP_SH_IR: tdo_next = ir_shift_reg[0];
		jcpp_pkg::TAP_SH_DR: begin
			case (sel)
			jcpp_pkg::SEL_BSR:  tdo_next = bsr_reg[0];
			jcpp_pkg::SEL_ID:   tdo_next = id_reg[0];
			jcpp_pkg::SEL_SIG:  tdo_next = user_signature[0];
			jcpp_pkg::SEL_ADDR: tdo_next = addr_reg[0];
			jcpp_pkg::SEL_COL:  tdo_next = col_reg[0];
			default:            tdo_next = bypass_reg;
			endcase
		end
		default: tdo_next = 1'b0;
		endcase
	end

	// tdo moves on the falling tck edge so the tester samples it settled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdo_o <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			tdo_o <= tdo_next;
			tdo_oe_n <= !(tap_reg == jcpp_pkg::TAP_SH_IR
				|| tap_reg == jcpp_pkg::TAP_SH_DR);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bs_drive_en <= 1'b0;
			outputs_highz <= 1'b0;
			extest_mode <= 1'b0;
			intest_mode <= 1'b0;
			bs_drive_value <= '0;
			normal_enable <= 1'b0;
		end else begin
			bs_drive_en <= ir_reg == jcpp_pkg::OP_EXTEST
				|| ir_reg == jcpp_pkg::OP_CLAMP
				|| ir_reg == jcpp_pkg::OP_NULL;
			outputs_highz <= ir_reg == jcpp_pkg::OP_HIGHZ;
			extest_mode <= ir_reg == jcpp_pkg::OP_EXTEST;
			intest_mode <= ir_reg == jcpp_pkg::OP_INTEST;
			bs_drive_value <= bsr_upd_reg;
			normal_enable <= done_reg;
		end
	end

	assign status = {16'h0000, ir_reg, 3'h0, vpp_reg,
		seq_reg != jcpp_pkg::SQ_IDLE, done_reg,
		readout_lock_fuse, prog_mode_reg};

	// one wait state: pready rises on the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			ctrl_en_reg <= jcpp_pkg::CTRL_RESET;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= '0;
			case (paddr)
			jcpp_pkg::REG_STATUS: prdata <= status;
			jcpp_pkg::REG_CTRL:   prdata <= {31'h0, ctrl_en_reg};
			jcpp_pkg::REG_ADDR:   prdata <= {22'h0, addr_reg};
			default:              pslverr <= 1'b1;
			endcase
		end else begin
			if (psel && penable && pwrite && !pslverr
				&& paddr == jcpp_pkg::REG_CTRL) begin
				ctrl_en_reg <= pwdata[jcpp_pkg::CTRL_EN];
			end
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule

//--- verification/jcpp_port_checker.sv
`timescale 1ns/1ps
module jcpp_port_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tck,
	input wire logic        bs_drive_en,
	input wire logic        outputs_highz,
	input wire logic        extest_mode,
	input wire logic        intest_mode
);
	default clocking dcb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	// six quiet samples outlast the synchroniser and decode delay
	sequence s_tck_quiet;
		!tck [*6];
	endsequence
	a_apb_one_wait: assert property (s_access |=> pready)
		else $error("no answer one cycle after access");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_error_needs_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_error_data_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	a_highz_no_drive: assert property (
		outputs_highz |-> !bs_drive_en && !extest_mode)
		else $error("pins driven while high-z");
	a_extest_drives: assert property (extest_mode |-> bs_drive_en)
		else $error("external test without pin drive");
	a_intest_alone: assert property (
		intest_mode |-> !extest_mode && !outputs_highz)
		else $error("internal test mixed with other mode");
	a_modes_hold: assert property (s_tck_quiet |=>
		$stable({extest_mode, intest_mode, outputs_highz, bs_drive_en}))
		else $error("mode changed while test clock idle");
endmodule

//--- verification/jcpp_jtag_host.sv
`timescale 1ns/1ps
module jcpp_jtag_host (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo_o,
	input  wire logic tdo_oe_n
);
	// tck stands low between frames; a released tdo reads as z
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	task automatic bit_t(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#290;
		q = tdo_oe_n ? 1'bz : tdo_o;
		#13 tck = 1'b1;
		#97 tck = 1'b0;
	endtask
	task automatic walk(input logic [7:0] m, input int n);
		logic q;
		#7;
		for (int i = 0; i < n; i++) begin
			bit_t(m[i], 1'b0, q);
		end
	endtask
	task automatic idle(input int n);
		logic q;
		#7;
		for (int i = 0; i < n; i++) begin
			bit_t(1'b0, 1'b0, q);
		end
	endtask
	// from run-test/idle, lsb first, back to idle through update
	task automatic scan(input logic ir, input int n,
		input logic [127:0] din, output logic [127:0] dout);
		logic q;
		dout = '0;
		walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		for (int i = 0; i < n; i++) begin
			bit_t(i == n - 1, din[i], q);
			dout[i] = q;
		end
		walk(8'h01, 2);
	endtask
endmodule

//--- verification/tb_jtag_config_programming_port.sv
`timescale 1ns/1ps
module tb_jtag_config_programming_port;
	typedef struct {
		logic [7:0]  op;
		int          len;
		logic [3:0]  md;
		logic [31:0] cap;
		bit          cc;
	} jcpp_row_t;
	localparam logic [127:0] DIN = 128'hc3a5_96e1_0f2d_4b87_1e3c_5a69_f0d2_b487;
	localparam logic [89:0]  PAT = 90'h2_a5c3_0ff0_9696_1234_abcd_ef;
	localparam logic [31:0]  SIG = 32'h6d2e_91b4;
	logic         pclk = 1'b0;
	logic         presetn = 1'b0;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata, r;
	logic [15:0]  pin_state = 16'h3c5a;
	logic [15:0]  bs_drive_value;
	logic         pready, pslverr, e, tck, tms, tdi, tdo_o, tdo_oe_n;
	logic         bs_drive_en, outputs_highz, extest_mode, intest_mode;
	logic         normal_enable;
	logic [127:0] q;
	int           err_count = 0;
	int           n_compared = 0;
	jcpp_row_t    rows [13];

	jcpp_port uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .pin_state(pin_state),
		.bs_drive_value(bs_drive_value), .bs_drive_en(bs_drive_en),
		.outputs_highz(outputs_highz), .extest_mode(extest_mode),
		.intest_mode(intest_mode), .normal_enable(normal_enable));
	jcpp_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi),
		.tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n));

	always #25 pclk = ~pclk;

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [127:0] x, g);
		n_compared++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			err_count++;
			results();
		end
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic stbit(input int b, input logic v);
		rd(jcpp_pkg::REG_STATUS);
		chk("status bit", v, r[b]);
	endtask
	task automatic ir(input logic [7:0] c);
		host.scan(1'b1, 8, {120'h0, c}, q);
		host.idle(4);
	endtask
	task automatic setaddr(input logic [9:0] a);
		ir(jcpp_pkg::OP_ADDR_SHIFT);
		host.scan(1'b0, 10, {118'h0, a}, q);
	endtask
	task automatic coldata(input logic [89:0] d);
		ir(jcpp_pkg::OP_DATA_SHIFT);
		host.scan(1'b0, 90, {38'h0, d}, q);
	endtask

	initial begin
		rows = '{
			'{jcpp_pkg::OP_EXTEST, 16, 4'h9, 32'h3c5a, 1'b1},
			'{jcpp_pkg::OP_SAMPLE, 16, 4'h0, 32'h3c5a, 1'b1},
			'{jcpp_pkg::OP_IDCODE, 32, 4'h0, jcpp_pkg::ID_VALUE, 1'b1},
			'{jcpp_pkg::OP_ADDR_SHIFT, 10, 4'h0, 32'h0, 1'b0},
			'{jcpp_pkg::OP_DATA_SHIFT, 90, 4'h0, 32'h0, 1'b0},
			'{jcpp_pkg::OP_USERCODE, 32, 4'h0, 32'h0, 1'b1},
			'{jcpp_pkg::OP_HIGHZ, 0, 4'h2, 32'h0, 1'b0},
			'{jcpp_pkg::OP_CLAMP, 0, 4'h1, 32'h0, 1'b0},
			'{jcpp_pkg::OP_NULL, 0, 4'h1, 32'h0, 1'b0},
			'{jcpp_pkg::OP_INTEST, 0, 4'h4, 32'h0, 1'b0},
			'{8'hff, 1, 4'h0, 32'h0, 1'b1},
			'{8'h80, 1, 4'h0, 32'h0, 1'b1},
			'{8'h05, 1, 4'h0, 32'h0, 1'b1}};
		repeat (5) @(posedge pclk);
		chk("reset outs", 8'h01, {pready, pslverr, bs_drive_en, outputs_highz,
			extest_mode, intest_mode, normal_enable, tdo_oe_n});
		presetn <= 1'b1;
		rd(jcpp_pkg::REG_STATUS);
		chk("status", 32'h0000_1600, r);
		apb(1'b1, jcpp_pkg::REG_CTRL, 32'h0);
		rd(jcpp_pkg::REG_CTRL);
		chk("ctrl", 32'h0, r);
		apb(1'b1, jcpp_pkg::REG_CTRL, 32'h1);
		apb(1'b1, jcpp_pkg::REG_ADDR, 32'h3ff);
		apb(1'b1, 12'h00c, 32'hffff_ffff);
		chk("slverr", 1'b1, e);
		rd(12'h00c);
		chk("unmapped", 33'h1_0000_0000, {e, r});
		rd(jcpp_pkg::REG_ADDR);
		chk("ro addr", 32'h0, r);
		$display("reset test done");
		host.walk(8'h1f, 6);
		host.scan(1'b0, 32, DIN, q);
		chk("blind id", jcpp_pkg::ID_VALUE, q[31:0]);
		for (int i = 0; i < 13; i++) begin
			// idle after the update edge lets the new modes settle
			ir(rows[i].op);
			chk("ir capture", 8'h16, q[7:0]);
			chk("mode", rows[i].md, {extest_mode, intest_mode,
				outputs_highz, bs_drive_en});
			if (rows[i].len > 0) begin
				host.scan(1'b0, rows[i].len + 8, DIN, q);
				chk("dr length", DIN[7:0], 8'(q >> rows[i].len));
				if (rows[i].cc)
					chk("capture", rows[i].cap, q[31:0] &
						~(32'hffff_ffff << rows[i].len));
			end
			if (rows[i].op === jcpp_pkg::OP_EXTEST) begin
				// update-dr lands a few pclk after the last tck rise
				repeat (4) @(posedge pclk);
				chk("drive", DIN[23:8], bs_drive_value);
			end
			$display("row %0d done", i);
		end
		setaddr(10'h005);
		ir(jcpp_pkg::OP_WR_STEP);
		rd(jcpp_pkg::REG_ADDR);
		chk("no step", 32'h5, r);
		ir(jcpp_pkg::OP_PROG_EN);
		stbit(jcpp_pkg::ST_PROG, 1'b1);
		ir(jcpp_pkg::OP_BULK_ERASE);
		host.idle(130);
		setaddr(10'h005);
		coldata(PAT);
		ir(jcpp_pkg::OP_PROGRAM);
		coldata(90'h0);
		chk("column held", PAT, q[89:0]);
		setaddr(10'h005);
		ir(jcpp_pkg::OP_RD_STEP);
		rd(jcpp_pkg::REG_ADDR);
		chk("read step", 32'h6, r);
		coldata(90'h0);
		chk("column", PAT, q[89:0]);
		ir(jcpp_pkg::OP_WR_STEP);
		rd(jcpp_pkg::REG_ADDR);
		chk("write step", 32'h7, r);
		$display("program test done");
		ir(jcpp_pkg::OP_USERCODE);
		host.scan(1'b0, 32, {96'h0, SIG}, q);
		ir(jcpp_pkg::OP_STORE_SIG);
		ir(jcpp_pkg::OP_USERCODE);
		host.scan(1'b0, 32, 128'h0, q);
		chk("signature", SIG, q[31:0]);
		stbit(jcpp_pkg::ST_VPP, 1'b1);
		ir(jcpp_pkg::OP_DISCHARGE);
		stbit(jcpp_pkg::ST_VPP, 1'b0);
		ir(jcpp_pkg::OP_PROG_DONE);
		chk("done set", 1'b1, normal_enable);
		ir(jcpp_pkg::OP_ERASE_DONE);
		chk("done clear", 1'b0, normal_enable);
		$display("signature test done");
		ir(jcpp_pkg::OP_FUSE_PROG);
		stbit(jcpp_pkg::ST_FUSE, 1'b1);
		coldata(PAT);
		setaddr(10'h005);
		ir(jcpp_pkg::OP_VERIFY);
		coldata(90'h0);
		chk("locked", 90'h0, q[89:0]);
		ir(jcpp_pkg::OP_BULK_ERASE);
		host.idle(130);
		stbit(jcpp_pkg::ST_FUSE, 1'b0);
		ir(jcpp_pkg::OP_USERCODE);
		host.scan(1'b0, 32, 128'h0, q);
		chk("sig erased", 32'h0, q[31:0]);
		ir(jcpp_pkg::OP_PROG_DIS);
		stbit(jcpp_pkg::ST_PROG, 1'b0);
		$display("fuse test done");
		results();
	end
endmodule

bind jcpp_port jcpp_port_checker chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .tck(tck),
	.bs_drive_en(bs_drive_en), .outputs_highz(outputs_highz),
	.extest_mode(extest_mode), .intest_mode(intest_mode));
